// ==== psfm_top.v ====
/*
 * per-core performance-state control, boost gate and effective-frequency
 * counters, reached as model-specific registers.
 * assumes the power manager, clock generator and idle logic share i_clk_sys.
 */
`timescale 1ns/1ps
`include "psfm_defs.vh"

module psfm_top #(
    parameter [3:0] MAX_STATE_INDEX = 4'hF,     // highest supported index
    parameter [3:0] RESET_REQUEST = `PSFM_RST_REQUEST // request after reset
) (
    input wire i_clk_sys,                   // system clock, 40 MHz
    input wire i_rst,                       // synchronous reset, high
    input wire i_msr_wr,                    // register write strobe
    input wire i_msr_rd,                    // register read strobe
    input wire [31:0] i_msr_addr,           // register address
    input wire [63:0] i_msr_wdata,          // write data
    output wire [63:0] o_msr_rdata,         // read data, one cycle after read
    output wire o_msr_done,                 // access completed pulse
    output wire o_general_protection_fault, // fault pulse for bad access
    input wire [3:0] i_hw_limit,            // limit from power management
    input wire i_power_over_limit,          // estimated power above limit
    input wire i_core_in_c0,                // core executing in C0
    input wire i_max_clk_tick,              // tick at maximum-performance rate
    input wire i_freq_ack,                  // clock generator reached target
    output wire o_freq_req,                 // frequency change request
    output wire [3:0] o_freq_state,         // state index for the generator
    output wire o_boost,                    // boost active
    output wire [3:0] o_present_state,      // state reached
    output wire o_hw_state_ctrl_supported   // feature bit for identification
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function [3:0] psfm_clip;
        input [3:0] idx;
        begin
            psfm_clip = (idx > MAX_STATE_INDEX) ? MAX_STATE_INDEX : idx;
        end
    endfunction

    function [3:0] psfm_slower;
        input [3:0] a;
        input [3:0] b;
        begin
            psfm_slower = (a > b) ? a : b;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state registers

    reg [3:0] request_reg;
    reg [3:0] limit_reg;
    reg boost_disable_reg;
    reg [63:0] actual_cnt_reg;
    reg [63:0] max_cnt_reg;
    reg [63:0] rdata_reg;
    reg done_reg;
    reg gp_reg;
    reg feature_reg;
    reg [3:0] target_reg;

    wire [3:0] present_state;
    wire hit_actual = (i_msr_addr == `PSFM_ADDR_ACTUAL_CLK);
    wire hit_max = (i_msr_addr == `PSFM_ADDR_MAX_CLK);
    wire hit_cfg = (i_msr_addr == `PSFM_ADDR_HW_CONFIG);
    wire hit_limit = (i_msr_addr == `PSFM_ADDR_STATE_LIMIT);
    wire hit_req = (i_msr_addr == `PSFM_ADDR_STATE_REQ);
    wire hit_now = (i_msr_addr == `PSFM_ADDR_STATE_NOW);
    wire hit_any = hit_actual | hit_max | hit_cfg | hit_limit | hit_req | hit_now;
    wire wr_ok = i_msr_wr && (hit_actual | hit_max | hit_cfg | hit_req);
    wire access = i_msr_wr | i_msr_rd;

    ////////////////////////////////////////////////////////////////////////
    // request, limit and configuration

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            request_reg <= psfm_clip(RESET_REQUEST);
            limit_reg <= `PSFM_RST_STATE;
            boost_disable_reg <= `PSFM_RST_BOOST_DIS;
            feature_reg <= 1'b0;
        end else begin
            if (wr_ok && hit_req) begin
                request_reg <= psfm_clip(i_msr_wdata[3:0]);
            end
            if (wr_ok && hit_cfg) begin
                boost_disable_reg <= i_msr_wdata[`PSFM_BOOST_DIS_BIT];
            end
            limit_reg <= psfm_clip(i_hw_limit);
            feature_reg <= 1'b1;
        end
    end

    // target follows the slower of request and limit, re-evaluated every cycle
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            target_reg <= `PSFM_RST_STATE;
        end else begin
            target_reg <= psfm_slower(request_reg, limit_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transition sequencer and boost

    psfm_freq_seq u_seq (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_target(target_reg),
        .i_boost_allow(!boost_disable_reg && !i_power_over_limit
            && (target_reg == 4'h0)),
        .i_freq_ack(i_freq_ack),
        .o_freq_req(o_freq_req),
        .o_freq_state(o_freq_state),
        .o_present_state(present_state),
        .o_boost(o_boost)
    );

    ////////////////////////////////////////////////////////////////////////
    // effective-frequency counters; a software write wins over a count

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            actual_cnt_reg <= `PSFM_RST_COUNT;
            max_cnt_reg <= `PSFM_RST_COUNT;
        end else begin
            if (wr_ok && hit_actual) begin
                actual_cnt_reg <= i_msr_wdata;
            end else if (i_core_in_c0) begin
                actual_cnt_reg <= actual_cnt_reg + 64'h0000000000000001;
            end
            if (wr_ok && hit_max) begin
                max_cnt_reg <= i_msr_wdata;
            end else if (i_core_in_c0 && i_max_clk_tick) begin
                max_cnt_reg <= max_cnt_reg + 64'h0000000000000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read and fault reporting

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            rdata_reg <= 64'h0000000000000000;
            done_reg <= 1'b0;
            gp_reg <= 1'b0;
        end else begin
            done_reg <= access;
            gp_reg <= access && (!hit_any || (i_msr_wr && (hit_limit | hit_now)));
            rdata_reg <= 64'h0000000000000000;
            if (i_msr_rd) begin
                if (hit_actual) begin
                    rdata_reg <= actual_cnt_reg;
                end else if (hit_max) begin
                    rdata_reg <= max_cnt_reg;
                end else if (hit_cfg) begin
                    rdata_reg[`PSFM_BOOST_DIS_BIT] <= boost_disable_reg;
                end else if (hit_limit) begin
                    rdata_reg[7:0] <= {MAX_STATE_INDEX, limit_reg};
                end else if (hit_req) begin
                    rdata_reg[3:0] <= request_reg;
                end else if (hit_now) begin
                    rdata_reg[3:0] <= present_state;
                end
            end
        end
    end

    assign o_msr_rdata = rdata_reg;
    assign o_msr_done = done_reg;
    assign o_general_protection_fault = gp_reg;
    assign o_present_state = present_state;
    assign o_hw_state_ctrl_supported = feature_reg;

endmodule // psfm_top

// ==== psfm_defs.vh ====
/*
 * constants for the performance-state and frequency monitor block:
 * register addresses, field positions and reset values.
 * assumes it is included by bare name from the design files.
 */
`ifndef PSFM_DEFS_VH
`define PSFM_DEFS_VH

// register addresses
`define PSFM_ADDR_ACTUAL_CLK    32'h000000E8
`define PSFM_ADDR_MAX_CLK       32'h000000E7
`define PSFM_ADDR_HW_CONFIG     32'hC0010015
`define PSFM_ADDR_STATE_LIMIT   32'hC0010061
`define PSFM_ADDR_STATE_REQ     32'hC0010062
`define PSFM_ADDR_STATE_NOW     32'hC0010063

// field positions
`define PSFM_LIMIT_CUR_LSB      0
`define PSFM_LIMIT_MAX_LSB      4
`define PSFM_BOOST_DIS_BIT      25
`define PSFM_STATE_W            4

// reset values
`define PSFM_RST_REQUEST        4'h0
`define PSFM_RST_STATE          4'h0
`define PSFM_RST_BOOST_DIS      1'b0
`define PSFM_RST_COUNT          64'h0000000000000000

// sequencer states
`define PSFM_SEQ_IDLE           1'b0
`define PSFM_SEQ_WAIT           1'b1

// boost power credit
`define PSFM_CREDIT_W           12
`define PSFM_CREDIT_MAX         12'hFFF

`endif

// ==== psfm_freq_seq.v ====
/*
 * frequency transition sequencer and boost gate.
 * assumes the clock generator answers each request with a one-cycle
 * acknowledge on the same clock once the new frequency is reached.
 */
`timescale 1ns/1ps
`include "psfm_defs.vh"

module psfm_freq_seq (
    input wire i_clk_sys,               // system clock
    input wire i_rst,                   // synchronous reset, high
    input wire [3:0] i_target,          // state index to reach
    input wire i_boost_allow,           // request and power allow boost
    input wire i_freq_ack,              // clock generator reached target
    output wire o_freq_req,             // transition request, level
    output wire [3:0] o_freq_state,     // state index asked of generator
    output wire [3:0] o_present_state,  // state actually reached
    output wire o_boost                 // boost above state 0 active
);

    localparam SEQ_IDLE = `PSFM_SEQ_IDLE;
    localparam SEQ_WAIT = `PSFM_SEQ_WAIT;

    reg seq_reg;
    reg seq_next;
    reg req_reg;
    reg req_next;
    reg [3:0] pend_reg;
    reg [3:0] pend_next;
    reg [3:0] present_reg;
    reg [3:0] present_next;
    reg boost_reg;
    reg [`PSFM_CREDIT_W-1:0] credit_reg;

    ////////////////////////////////////////////////////////////////////////
    always @* begin
        seq_next = seq_reg;
        req_next = req_reg;
        pend_next = pend_reg;
        present_next = present_reg;
        case (seq_reg)
            SEQ_IDLE: begin
                if (i_target != present_reg) begin
                    pend_next = i_target;
                    req_next = 1'b1;
                    seq_next = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (i_freq_ack) begin
                    present_next = pend_reg;
                    req_next = 1'b0;
                    seq_next = SEQ_IDLE;
                end
            end
            default: begin
                seq_next = SEQ_IDLE;
                req_next = 1'b0;
            end
        endcase
    end

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            seq_reg <= SEQ_IDLE;
            req_reg <= 1'b0;
            pend_reg <= `PSFM_RST_STATE;
            present_reg <= `PSFM_RST_STATE;
        end else begin
            seq_reg <= seq_next;
            req_reg <= req_next;
            pend_reg <= pend_next;
            present_reg <= present_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // credit drains while boosting and refills otherwise, bounding average power
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            credit_reg <= `PSFM_CREDIT_MAX;
            boost_reg <= 1'b0;
        end else begin
            if (boost_reg && credit_reg != {`PSFM_CREDIT_W{1'b0}}) begin
                credit_reg <= credit_reg - 1'b1;
            end else if (!boost_reg && credit_reg != `PSFM_CREDIT_MAX) begin
                credit_reg <= credit_reg + 1'b1;
            end
            boost_reg <= i_boost_allow && (present_reg == 4'h0) && (seq_reg == SEQ_IDLE)
                && (credit_reg != {`PSFM_CREDIT_W{1'b0}});
        end
    end

    assign o_freq_req = req_reg;
    assign o_freq_state = pend_reg;
    assign o_present_state = present_reg;
    assign o_boost = boost_reg;

endmodule // psfm_freq_seq

// ==== psfm_top_sva.sv ====
/* checker for psfm_top: bus answers, faults, frequency link, boost gate.
   assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
`include "psfm_defs.vh"

module psfm_sva #(
    parameter [3:0] MAX_STATE_INDEX = 4'hF
) (
    input wire i_clk_sys, // clock
    input wire i_rst, // reset
    input wire i_msr_wr, // write strobe
    input wire i_msr_rd, // read strobe
    input wire [31:0] i_msr_addr, // address
    input wire [63:0] o_msr_rdata, // read data
    input wire o_msr_done, // done pulse
    input wire o_general_protection_fault, // fault pulse
    input wire i_power_over_limit, // power high
    input wire i_freq_ack, // generator ack
    input wire o_freq_req, // transition request
    input wire [3:0] o_freq_state, // asked state
    input wire [3:0] o_present_state, // reached state
    input wire o_boost, // boost active
    input wire o_hw_state_ctrl_supported // feature bit
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    wire strobe = i_msr_wr | i_msr_rd;
    wire xfer = o_freq_req & i_freq_ack;
    wire ro_wr = i_msr_wr && (i_msr_addr == `PSFM_ADDR_STATE_LIMIT ||
        i_msr_addr == `PSFM_ADDR_STATE_NOW);
    ////////////////////////////////////////////////////////////
    done_follows_a: assert property (strobe |=> o_msr_done)
        else $error("access not answered");
    done_cause_a: assert property (o_msr_done |-> $past(strobe))
        else $error("done without access");
    ro_fault_a: assert property (ro_wr |=> o_general_protection_fault)
        else $error("read-only write not faulted");
    rdata_idle_a: assert property (!i_msr_rd |=> o_msr_rdata == 64'h0)
        else $error("read data not zero");
    limit_fmt_a: assert property (i_msr_rd && i_msr_addr == `PSFM_ADDR_STATE_LIMIT
        |=> o_msr_rdata[63:4] == {56'h0, MAX_STATE_INDEX}) else $error("limit format");
    status_read_a: assert property (i_msr_rd && i_msr_addr == `PSFM_ADDR_STATE_NOW
        |=> o_msr_rdata == {60'h0, $past(o_present_state)}) else $error("status read");
    present_hold_a: assert property (!xfer |=> $stable(o_present_state))
        else $error("state moved without ack");
    ack_lands_a: assert property (xfer |=> o_present_state == $past(o_freq_state)
        && !o_freq_req) else $error("ack not applied");
    req_holds_a: assert property (o_freq_req && !i_freq_ack |=> o_freq_req
        && $stable(o_freq_state)) else $error("request dropped");
    boost_gate_a: assert property (o_boost |-> o_present_state == 4'h0
        && !$past(i_power_over_limit)) else $error("boost when not allowed");
    feature_on_a: assert property (!i_rst |=> o_hw_state_ctrl_supported)
        else $error("feature bit low");
endmodule // psfm_sva

bind psfm_top psfm_sva #(.MAX_STATE_INDEX(MAX_STATE_INDEX)) psfm_sva_inst (.*);

// ==== tb.sv ====
/* testbench for psfm_top: requests, limits, counters and boost vs a model.
   assumes psfm_defs.vh and a 40 MHz clock. */
`timescale 1ns/1ps
`include "psfm_defs.vh"

module tb;
    localparam [3:0] MX = 4'h7;
    reg i_clk_sys = 1'b0, i_rst = 1'b1, i_msr_wr = 1'b0, i_msr_rd = 1'b0;
    reg [31:0] i_msr_addr = 32'h0;
    reg [63:0] i_msr_wdata = 64'h0;
    reg [3:0] i_hw_limit = 4'h0;
    reg i_power_over_limit = 1'b0, i_core_in_c0 = 1'b0, i_max_clk_tick = 1'b0;
    reg i_freq_ack = 1'b0;
    wire [63:0] o_msr_rdata;
    wire o_msr_done, o_general_protection_fault, o_freq_req, o_boost;
    wire o_hw_state_ctrl_supported;
    wire [3:0] o_freq_state, o_present_state;
    integer fail_count = 0, n_compared = 0, i, k, pres = 0, tgt;
    reg [31:0] rs = 32'h000130EA;
    reg [63:0] rd, a, m;
    reg [3:0] rq, lm;
    reg ft;

    psfm_top #(.MAX_STATE_INDEX(MX)) psfm_top_inst (.*);

    initial begin
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    ////////////////////////////////////////////////////////////
    task nx;
        begin
            rs = rs ^ (rs << 13);
            rs = rs ^ (rs >> 17);
            rs = rs ^ (rs << 5);
        end
    endtask
    function [3:0] clip(input [3:0] v);
        clip = (v > MX) ? MX : v;
    endfunction
    task st;
        begin
            @(posedge i_clk_sys);
            #1;
        end
    endtask
    task wrap_up;
        begin
            if (fail_count == 0 && n_compared > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [63:0] seen, input [63:0] exp, input [63:0] nm);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("ERROR %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // one access, then one idle cycle; called just after an edge
    task acc(input w, input [31:0] ad, input [63:0] d);
        begin
            i_msr_wr = w;
            i_msr_rd = !w;
            i_msr_addr = ad;
            i_msr_wdata = d;
            st;
            i_msr_wr = 1'b0;
            i_msr_rd = 1'b0;
            rd = o_msr_rdata;
            ft = o_general_protection_fault;
            chk(o_msr_done, 1, "done");
            st;
        end
    endtask
    task go(input [3:0] q, input [3:0] l);
        begin
            tgt = (clip(q) > clip(l)) ? clip(q) : clip(l);
            i_hw_limit = l;
            acc(1, `PSFM_ADDR_STATE_REQ, {60'h0, q});
            if (tgt != pres) begin
                i = 0;
                while (o_freq_req !== 1'b1 && i < 10) begin
                    st;
                    i = i + 1;
                end
                if (o_freq_req !== 1'b1) begin
                    fail_count = fail_count + 1;
                    wrap_up;
                end
                chk(o_freq_state, tgt, "fstate");
                chk(o_present_state, pres, "early");
                nx;
                repeat (rs[1:0]) st;
                i_freq_ack = 1'b1;
                st;
                i_freq_ack = 1'b0;
                st;
                pres = tgt;
            end
            chk(o_present_state, pres, "present");
        end
    endtask
    task wb;
        begin
            i = 0;
            while (o_boost !== 1'b1 && i < 8) begin
                st;
                i = i + 1;
            end
            if (o_boost !== 1'b1) begin
                fail_count = fail_count + 1;
                wrap_up;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge i_clk_sys);
        #1;
        i_rst = 1'b0;
        st;
        chk(o_hw_state_ctrl_supported, 1, "feature");
        chk(o_present_state, 0, "rstate");
        for (k = 0; k < 12; k = k + 1) begin
            nx;
            rq = rs[7:4];
            lm = rs[11:8];
            i_core_in_c0 = rs[12];
            go(rq, lm);
            acc(0, `PSFM_ADDR_STATE_NOW, 0);
            chk(rd, pres, "status");
            chk(ft, 0, "okfault");
            acc(0, `PSFM_ADDR_STATE_REQ, 0);
            chk(rd, clip(rq), "request");
            acc(0, `PSFM_ADDR_STATE_LIMIT, 0);
            chk(rd, {MX, clip(lm)}, "limit");
            acc(1, k[0] ? `PSFM_ADDR_STATE_NOW : `PSFM_ADDR_STATE_LIMIT, 64'hFF);
            chk(ft, 1, "rofault");
        end
        acc(0, 32'h00000010, 0);
        chk(ft, 1, "unmapped");
        i_core_in_c0 = 1'b0;
        a = 64'hFFFFFFFFFFFFFFFD;
        m = 64'hFFFFFFFFFFFFFFFE;
        acc(1, `PSFM_ADDR_ACTUAL_CLK, a);
        acc(1, `PSFM_ADDR_MAX_CLK, m);
        for (i = 0; i < 20; i = i + 1) begin
            nx;
            i_core_in_c0 = rs[0];
            i_max_clk_tick = rs[1];
            st;
            a = a + rs[0];
            m = m + (rs[0] & rs[1]);
        end
        i_core_in_c0 = 1'b0;
        acc(0, `PSFM_ADDR_ACTUAL_CLK, 0);
        chk(rd, a, "actual");
        acc(0, `PSFM_ADDR_MAX_CLK, 0);
        chk(rd, m, "refcnt");
        go(4'h0, 4'h0);
        wb;
        chk(o_boost, 1, "boost");
        acc(1, `PSFM_ADDR_HW_CONFIG, 64'hFFFFFFFFFFFFFFFF);
        chk(o_boost, 0, "boostoff");
        acc(0, `PSFM_ADDR_HW_CONFIG, 0);
        chk(rd, 64'h0000000002000000, "boostcfg");
        acc(1, `PSFM_ADDR_HW_CONFIG, 0);
        wb;
        i_power_over_limit = 1'b1;
        st;
        chk(o_boost, 0, "overlim");
        i_power_over_limit = 1'b0;
        wb;
        i = 0;
        while (o_boost === 1'b1 && i < 4200) begin
            st;
            i = i + 1;
        end
        chk(o_boost, 0, "credit");
        wrap_up;
    end
endmodule // tb
